// ===== shared/twa_pkg.sv
package twa_pkg;
   // address patterns
   localparam logic [7:0] GC_ADDR = 8'h00;
   localparam logic [4:0] EXT_PREFIX = 5'h1E;
   // bit positions within a byte on the bus
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [3:0] BIT_ACK = 4'h9;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_CNT = 4'h0;
   localparam logic RST_BIT = 1'b0;
   // baud divider
   localparam int BAUD_W = 8;
   localparam logic [BAUD_W-1:0] BAUD_RST = 8'h00;
   // master sequencer states
   typedef enum logic [3:0] {
      M_IDLE, M_START, M_LOW, M_HOLD, M_RUN, M_RSTA, M_RSTB, M_STOPA, M_STOPB
   } twa_mstate_e;
endpackage

// ===== shared/twa_line_if.sv
`timescale 1ns/1ps
interface twa_line_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic busy;
   modport src (output scl, sda, scl_rise, scl_fall, start_det, stop_det, busy);
   modport snk (input scl, sda, scl_rise, scl_fall, start_det, stop_det, busy);
endinterface

// ===== rtl/twa_line_sync.sv
`timescale 1ns/1ps
module twa_line_sync
   import twa_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   twa_line_if.src lp
);
   logic [2:0] scl_r, scl_nxt;
   logic [2:0] sda_r, sda_nxt;
   logic busy_r, busy_nxt;
   logic start_c, stop_c;

   // shift pins through two flops, third stage gives edges
   always_comb begin
      scl_nxt = {scl_r[1:0], scl_in};
      sda_nxt = {sda_r[1:0], sda_in};
      start_c = scl_r[1] & scl_r[2] & ~sda_r[1] & sda_r[2];
      stop_c = scl_r[1] & scl_r[2] & sda_r[1] & ~sda_r[2];
      busy_nxt = busy_r;
      if (start_c) begin
         busy_nxt = 1'b1;
      end else if (stop_c) begin
         busy_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         scl_r <= 3'h7;
         sda_r <= 3'h7;
         busy_r <= RST_BIT;
      end else begin
         scl_r <= scl_nxt;
         sda_r <= sda_nxt;
         busy_r <= busy_nxt;
      end
   end

   // decoded line events for the core
   assign lp.scl = scl_r[1];
   assign lp.sda = sda_r[1];
   assign lp.scl_rise = scl_r[1] & ~scl_r[2];
   assign lp.scl_fall = ~scl_r[1] & scl_r[2];
   assign lp.start_det = start_c;
   assign lp.stop_det = stop_c;
   assign lp.busy = busy_r;

   a_start_busy: assert property (@(posedge clock) disable iff (rst)
      start_c |=> busy_r) else $error("bus not busy after start");
endmodule

// ===== rtl/twa_baud_div.sv
`timescale 1ns/1ps
module twa_baud_div
   import twa_pkg::*;
#(
   parameter int W = BAUD_W
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic run,
   input wire logic [W-1:0] divisor,
   output logic tick
);
   logic [W-1:0] cnt_r, cnt_nxt;

   // one pulse every divisor+1 cycles while running
   always_comb begin
      tick = run && (cnt_r == '0);
      cnt_nxt = cnt_r;
      if (!run || cnt_r == '0) begin
         cnt_nxt = divisor;
      end else begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_r <= BAUD_RST;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// ===== rtl/twa_core.sv
// How it works
// - a slave holds SCL low to stretch the low phase; longest low wins.
// - extended first address byte is 11110, two upper bits, direction bit.
// - after START, match extended prefix and upper bits with write direction; ack.
// - matched slaves compare second byte fully; only exact match acknowledges.
// - selected slave stays selected until STOP or repeated START to other address.
// - first extended byte raises interrupt; software discards data register then.
// - after repeated START, fully addressed slave accepts prefix with read, transmits.
// - unaddressed slaves never select on repeated START with read direction.
// - general-call enable accepts address zero as slave receiver, sets addressed flag.
// - with general call disabled, address zero is not acknowledged.
// - disabled after reset; the block has no way to reset the system.
// - one interrupt output: flag gated by enable; set by byte, match, arbitration.
// - interrupt flag cleared by writing one; zero leaves it.
// - transfer-complete flag sets on falling edge of ninth clock.
// - addressed flag on own or general call; software then sets transmit select.
// - arbitration lost if SDA driven high reads low in address, data, master ack.
// - arbitration lost on start while busy, repeat in slave, unrequested STOP.
// - arbitration-lost flag sets interrupt flag, cleared only by writing one.
// - master setup: divider, enable, transmit, master, then address write starts.
// - address extension selects ten-bit mode; three-bit field gives upper bits.
// - losing master releases SDA at once, becomes slave receiver, no STOP.
`timescale 1ns/1ps
module twa_core
   import twa_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic module_enable,
   input wire logic bus_interrupt_enable,
   input wire logic master_select,
   input wire logic transmit_select,
   input wire logic repeat_start_req,
   input wire logic ack_disable,
   input wire logic general_call_enable,
   input wire logic address_extension,
   input wire logic [2:0] upper_address,
   input wire logic [7:0] own_address_reg,
   input wire logic [BAUD_W-1:0] baud_divider_reg,
   input wire logic [7:0] tx_data,
   input wire logic tx_data_wr,
   input wire logic clr_bus_interrupt_flag,
   input wire logic clr_arbitration_lost,
   output logic [7:0] bus_data_register,
   output logic transfer_complete_flag,
   output logic addressed_as_slave_flag,
   output logic slave_read_write_flag,
   output logic arbitration_lost_flag,
   output logic bus_interrupt_flag,
   output logic rx_nack,
   output logic bus_busy,
   output logic bus_interrupt
);
   twa_line_if lp ();
   logic tick;

   // engine state
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] shreg_r, shreg_nxt, data_r, data_nxt;
   logic sda_low_r, sda_low_nxt, stretch_r, stretch_nxt;
   logic selected_r, selected_nxt, ext_pend_r, ext_pend_nxt, ext_addr_r, ext_addr_nxt;
   logic addr_phase_r, addr_phase_nxt, srw_r, srw_nxt, nack_r, nack_nxt;
   logic tcf_r, tcf_nxt, addressed_as_slave_flag_r, addressed_as_slave_flag_nxt, arbitration_lost_flag_r, arbitration_lost_flag_nxt, iif_r, iif_nxt;
   // master state
   twa_mstate_e mstate_r, mstate_nxt;
   logic mst_r, mst_nxt, scl_low_r, scl_low_nxt, m_sda_low_r, m_sda_low_nxt;
   logic msel_q_r, msel_q_nxt, need_data_r, need_data_nxt, hi_seen_r, hi_seen_nxt;
   // combinational helpers
   logic ack_slot, byte_end, tx_dir, arb_evt, iif_set, addressed_as_slave_flag_set, ms_rise;
   logic gc_hit, own7_hit, pfx_hit;

   twa_line_sync u_sync (
      .clock(clock),
      .rst(rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .lp(lp)
   );

   twa_baud_div #(.W(BAUD_W)) u_div (
      .clock(clock),
      .rst(rst),
      .run(mst_r),
      .divisor(baud_divider_reg),
      .tick(tick)
   );

   // does the first address byte carry the ten-bit prefix and our upper bits
   function automatic logic ext_prefix_ok(input logic [7:0] b, input logic [2:0] up);
      ext_prefix_ok = (b[7:3] == EXT_PREFIX) && (b[2:1] == up[1:0]);
   endfunction

   // bus events and arbitration checks
   always_comb begin
      ack_slot = lp.scl_fall && (cnt_r == BIT_LAST);
      byte_end = lp.scl_fall && (cnt_r == BIT_ACK);
      ms_rise = master_select && !msel_q_r;
      tx_dir = mst_r ? (addr_phase_r | transmit_select)
                     : (selected_r & ~addr_phase_r & transmit_select);
      gc_hit = general_call_enable && (shreg_r == GC_ADDR);
      own7_hit = !address_extension && (shreg_r[7:1] == own_address_reg[7:1]);
      pfx_hit = address_extension && ext_prefix_ok(shreg_r, upper_address);
      arb_evt = module_enable && (
         (mst_r && lp.scl_rise && !sda_low_r && !m_sda_low_r && !lp.sda
            && (tx_dir ? (cnt_r < BIT_LAST) : (cnt_r == BIT_LAST)))
         || (ms_rise && !mst_r && lp.busy)
         || (repeat_start_req && !mst_r)
         || (lp.stop_det && mst_r));
   end

   // byte engine, address matching and status flags
   always_comb begin
      cnt_nxt = cnt_r;
      shreg_nxt = shreg_r;
      data_nxt = data_r;
      sda_low_nxt = sda_low_r;
      stretch_nxt = stretch_r;
      selected_nxt = selected_r;
      ext_pend_nxt = ext_pend_r;
      ext_addr_nxt = ext_addr_r;
      addr_phase_nxt = addr_phase_r;
      srw_nxt = srw_r;
      nack_nxt = nack_r;
      tcf_nxt = tcf_r;
      addressed_as_slave_flag_set = 1'b0;
      iif_set = 1'b0;
      addressed_as_slave_flag_nxt = addressed_as_slave_flag_r;
      if (lp.start_det) begin
         // repeated or fresh start: next byte is an address
         cnt_nxt = BIT_FIRST;
         addr_phase_nxt = 1'b1;
         sda_low_nxt = 1'b0;
         stretch_nxt = 1'b0;
         ext_pend_nxt = 1'b0;
         addressed_as_slave_flag_nxt = 1'b0;
      end else if (lp.stop_det) begin
         cnt_nxt = BIT_FIRST;
         addr_phase_nxt = 1'b0;
         selected_nxt = 1'b0;
         ext_addr_nxt = 1'b0;
         ext_pend_nxt = 1'b0;
         sda_low_nxt = 1'b0;
         stretch_nxt = 1'b0;
         addressed_as_slave_flag_nxt = 1'b0;
      end else begin
         if (lp.scl_rise && cnt_r < BIT_ACK) begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r < BIT_LAST) begin
               shreg_nxt = {shreg_r[6:0], lp.sda};
            end else begin
               nack_nxt = lp.sda;
            end
            if (cnt_r == BIT_FIRST) begin
               tcf_nxt = 1'b0;
            end
         end
         if (lp.scl_fall && cnt_r != BIT_FIRST && cnt_r < BIT_LAST) begin
            sda_low_nxt = tx_dir & ~shreg_r[7];
         end
         if (ack_slot) begin
            data_nxt = shreg_r;
            if (addr_phase_r && !mst_r) begin
               sda_low_nxt = 1'b0;
               if (ext_pend_r) begin
                  ext_pend_nxt = 1'b0;
                  if (shreg_r == own_address_reg) begin
                     sda_low_nxt = 1'b1;
                     selected_nxt = 1'b1;
                     ext_addr_nxt = 1'b1;
                     srw_nxt = 1'b0;
                     addressed_as_slave_flag_set = 1'b1;
                  end else begin
                     selected_nxt = 1'b0;
                     ext_addr_nxt = 1'b0;
                  end
               end else if (gc_hit || own7_hit) begin
                  sda_low_nxt = 1'b1;
                  selected_nxt = 1'b1;
                  srw_nxt = gc_hit ? 1'b0 : shreg_r[0];
                  addressed_as_slave_flag_set = 1'b1;
               end else if (pfx_hit && !shreg_r[0]) begin
                  sda_low_nxt = 1'b1;
                  ext_pend_nxt = 1'b1;
                  selected_nxt = 1'b0;
                  ext_addr_nxt = 1'b0;
               end else if (pfx_hit && ext_addr_r) begin
                  sda_low_nxt = 1'b1;
                  selected_nxt = 1'b1;
                  srw_nxt = 1'b1;
                  addressed_as_slave_flag_set = 1'b1;
               end else begin
                  selected_nxt = 1'b0;
                  ext_addr_nxt = 1'b0;
               end
            end else begin
               sda_low_nxt = !tx_dir && (mst_r ? !ack_disable : selected_r);
            end
         end
         if (byte_end) begin
            cnt_nxt = BIT_FIRST;
            sda_low_nxt = 1'b0;
            tcf_nxt = 1'b1;
            iif_set = 1'b1;
            addr_phase_nxt = ext_pend_r && !mst_r;
            stretch_nxt = selected_r && !mst_r;
         end else if (stretch_r && !iif_r) begin
            stretch_nxt = 1'b0;
         end
         if (tx_data_wr) begin
            shreg_nxt = tx_data;
            data_nxt = tx_data;
            addressed_as_slave_flag_nxt = 1'b0;
            if (cnt_r == BIT_FIRST) begin
               sda_low_nxt = tx_dir & ~tx_data[7];
            end
         end
      end
      if (arb_evt) begin
         sda_low_nxt = 1'b0;
      end
      // set wins over software clear
      iif_set = iif_set | addressed_as_slave_flag_set | arb_evt;
      iif_nxt = iif_set | (iif_r & ~clr_bus_interrupt_flag);
      arbitration_lost_flag_nxt = arb_evt | (arbitration_lost_flag_r & ~clr_arbitration_lost);
      addressed_as_slave_flag_nxt = addressed_as_slave_flag_set | addressed_as_slave_flag_nxt;
      if (!module_enable) begin
         cnt_nxt = RST_CNT;
         sda_low_nxt = 1'b0;
         stretch_nxt = 1'b0;
         selected_nxt = 1'b0;
         ext_pend_nxt = 1'b0;
         ext_addr_nxt = 1'b0;
         addr_phase_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_r <= RST_CNT;
         shreg_r <= RST_BYTE;
         data_r <= RST_BYTE;
         sda_low_r <= RST_BIT;
         stretch_r <= RST_BIT;
         selected_r <= RST_BIT;
         ext_pend_r <= RST_BIT;
         ext_addr_r <= RST_BIT;
         addr_phase_r <= RST_BIT;
         srw_r <= RST_BIT;
         nack_r <= RST_BIT;
         tcf_r <= RST_BIT;
         addressed_as_slave_flag_r <= RST_BIT;
         arbitration_lost_flag_r <= RST_BIT;
         iif_r <= RST_BIT;
      end else begin
         cnt_r <= cnt_nxt;
         shreg_r <= shreg_nxt;
         data_r <= data_nxt;
         sda_low_r <= sda_low_nxt;
         stretch_r <= stretch_nxt;
         selected_r <= selected_nxt;
         ext_pend_r <= ext_pend_nxt;
         ext_addr_r <= ext_addr_nxt;
         addr_phase_r <= addr_phase_nxt;
         srw_r <= srw_nxt;
         nack_r <= nack_nxt;
         tcf_r <= tcf_nxt;
         addressed_as_slave_flag_r <= addressed_as_slave_flag_nxt;
         arbitration_lost_flag_r <= arbitration_lost_flag_nxt;
         iif_r <= iif_nxt;
      end
   end

   // master sequencer: start, clocking with synchronisation, repeat and stop
   always_comb begin
      mstate_nxt = mstate_r;
      mst_nxt = mst_r;
      scl_low_nxt = scl_low_r;
      m_sda_low_nxt = m_sda_low_r;
      need_data_nxt = need_data_r & ~tx_data_wr;
      hi_seen_nxt = hi_seen_r;
      msel_q_nxt = master_select;
      case (mstate_r)
         M_IDLE: begin
            if (ms_rise && !lp.busy && module_enable) begin
               mstate_nxt = M_START;
               mst_nxt = 1'b1;
               m_sda_low_nxt = 1'b1;
            end
         end
         M_START: begin
            if (tick) begin
               mstate_nxt = M_LOW;
               scl_low_nxt = 1'b1;
            end
         end
         M_LOW: begin
            if (tick) begin
               mstate_nxt = M_HOLD;
               m_sda_low_nxt = 1'b0;
               need_data_nxt = ~tx_data_wr;
            end
         end
         M_HOLD: begin
            if (repeat_start_req) begin
               mstate_nxt = M_RSTA;
            end else if (!master_select) begin
               mstate_nxt = M_STOPA;
               m_sda_low_nxt = 1'b1;
            end else if (!iif_r && !need_data_nxt) begin
               mstate_nxt = M_RUN;
               hi_seen_nxt = 1'b0;
            end
         end
         M_RUN: begin
            if (byte_end) begin
               mstate_nxt = M_HOLD;
               need_data_nxt = transmit_select;
            end else if (scl_low_r) begin
               if (tick) begin
                  scl_low_nxt = 1'b0;
                  hi_seen_nxt = 1'b0;
               end
            end else if (tick && lp.scl) begin
               // high phase counts only once the wire is really high
               scl_low_nxt = hi_seen_r;
               hi_seen_nxt = 1'b1;
            end
         end
         M_RSTA: begin
            if (tick) begin
               mstate_nxt = M_RSTB;
               scl_low_nxt = 1'b0;
            end
         end
         M_RSTB: begin
            if (tick && lp.scl) begin
               mstate_nxt = M_START;
               m_sda_low_nxt = 1'b1;
            end
         end
         M_STOPA: begin
            if (tick) begin
               mstate_nxt = M_STOPB;
               scl_low_nxt = 1'b0;
            end
         end
         M_STOPB: begin
            if (tick && lp.scl) begin
               mstate_nxt = M_IDLE;
               m_sda_low_nxt = 1'b0;
               mst_nxt = 1'b0;
            end
         end
         default: begin
            mstate_nxt = M_IDLE;
         end
      endcase
      if (arb_evt || !module_enable) begin
         // drop off the bus at once, no stop condition
         mstate_nxt = M_IDLE;
         mst_nxt = 1'b0;
         scl_low_nxt = 1'b0;
         m_sda_low_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mstate_r <= M_IDLE;
         mst_r <= RST_BIT;
         scl_low_r <= RST_BIT;
         m_sda_low_r <= RST_BIT;
         msel_q_r <= RST_BIT;
         need_data_r <= RST_BIT;
         hi_seen_r <= RST_BIT;
      end else begin
         mstate_r <= mstate_nxt;
         mst_r <= mst_nxt;
         scl_low_r <= scl_low_nxt;
         m_sda_low_r <= m_sda_low_nxt;
         msel_q_r <= msel_q_nxt;
         need_data_r <= need_data_nxt;
         hi_seen_r <= hi_seen_nxt;
      end
   end

   // pins and status outputs
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = scl_low_r | stretch_r;
   assign sda_oe = sda_low_r | m_sda_low_r;
   assign bus_data_register = data_r;
   assign transfer_complete_flag = tcf_r;
   assign addressed_as_slave_flag = addressed_as_slave_flag_r;
   assign slave_read_write_flag = srw_r;
   assign arbitration_lost_flag = arbitration_lost_flag_r;
   assign bus_interrupt_flag = iif_r;
   assign rx_nack = nack_r;
   assign bus_busy = lp.busy;
   assign bus_interrupt = iif_r & bus_interrupt_enable;

   a_irq_drop: assert property (@(posedge clock) disable iff (rst)
      (iif_r && clr_bus_interrupt_flag && !iif_set) |=> !bus_interrupt)
      else $error("interrupt did not drop after clear");
   a_tcf_ninth: assert property (@(posedge clock) disable iff (rst)
      (byte_end && module_enable && !lp.start_det && !lp.stop_det) |=> (tcf_r && iif_r))
      else $error("ninth fall did not set complete flag");
   a_arbitration_lost_flag_sticky: assert property (@(posedge clock) disable iff (rst)
      (arbitration_lost_flag_r && !clr_arbitration_lost) |=> arbitration_lost_flag_r)
      else $error("arbitration flag lost without clear");
   a_arb_release: assert property (@(posedge clock) disable iff (rst)
      arb_evt |=> (mstate_r == M_IDLE) && !mst_r && !m_sda_low_r && !sda_low_r && arbitration_lost_flag_r)
      else $error("master did not release after arbitration loss");
   a_gc_reject: assert property (@(posedge clock) disable iff (rst)
      (ack_slot && addr_phase_r && !mst_r && !ext_pend_r && !general_call_enable
       && !address_extension && shreg_r == GC_ADDR && own_address_reg[7:1] != 7'h00
       && !lp.start_det && !lp.stop_det) |=> !sda_low_r && !selected_r)
      else $error("general call acknowledged while disabled");
   a_read_reject: assert property (@(posedge clock) disable iff (rst)
      (ack_slot && addr_phase_r && !mst_r && !ext_pend_r && !ext_addr_r && address_extension
       && shreg_r[0] && !gc_hit && !lp.start_det && !lp.stop_det) |=> !selected_r)
      else $error("read selected without prior addressing");
   a_stop_deselect: assert property (@(posedge clock) disable iff (rst)
      lp.stop_det |=> !selected_r && !addressed_as_slave_flag_r)
      else $error("slave still selected after stop");
   a_stretch_hold: assert property (@(posedge clock) disable iff (rst)
      (stretch_r && iif_r && module_enable && !lp.start_det && !lp.stop_det) |=> scl_oe)
      else $error("stretch released while flag pending");
   a_disabled_quiet: assert property (@(posedge clock) disable iff (rst)
      !module_enable |=> !sda_oe && !scl_oe && !mst_r)
      else $error("disabled block drives the bus");
endmodule

// ===== sim/twa_host_model.sv
`timescale 1ns/1ps
module twa_host_model (
   input wire logic clock,
   input wire logic scl,
   input wire logic sda,
   output logic scl_low,
   output logic sda_low,
   output logic ack_stb,
   output logic ack_val
);
   localparam int HALF = 8;
   // lines released at time zero
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      ack_stb = 1'b0;
      ack_val = 1'b0;
   end
   // wait whole clocks, then step off the edge
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask
   // release scl and wait while a slave stretches it
   task automatic rel_scl();
      int k;
      k = 0;
      scl_low = 1'b0;
      while (scl !== 1'b1 && k < 4000) begin
         wt(1);
         k++;
      end
      wt(HALF);
   endtask
   // start or repeated start: sda falls while scl is high
   task automatic start();
      sda_low = 1'b0;
      wt(HALF);
      rel_scl();
      sda_low = 1'b1;
      wt(HALF);
      scl_low = 1'b1;
      wt(HALF);
   endtask
   // stop: sda rises while scl is high
   task automatic stop();
      sda_low = 1'b1;
      wt(HALF);
      rel_scl();
      sda_low = 1'b0;
      wt(HALF);
   endtask
   // eight bits msb first, then sample the acknowledge bit
   task automatic put_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sda_low = ~b[i];
         wt(HALF);
         rel_scl();
         scl_low = 1'b1;
      end
      sda_low = 1'b0;
      wt(HALF);
      rel_scl();
      ack_val = sda;
      ack_stb = 1'b1;
      wt(1);
      ack_stb = 1'b0;
      scl_low = 1'b1;
      wt(HALF);
   endtask
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import twa_pkg::*;
   logic clock, rst, scl_out, scl_oe, sda_out, sda_oe, scl_w, sda_w, m_scl, m_sda, ack_stb, ack_val;
   logic module_enable, bus_interrupt_enable, master_select, transmit_select, repeat_start_req;
   logic ack_disable, general_call_enable, address_extension, tx_data_wr;
   logic clr_bus_interrupt_flag, clr_arbitration_lost, transfer_complete_flag;
   logic addressed_as_slave_flag, slave_read_write_flag, arbitration_lost_flag;
   logic bus_interrupt_flag, rx_nack, bus_busy, bus_interrupt;
   logic [2:0] upper_address;
   logic [7:0] own_address_reg, tx_data, bus_data_register, fb, d;
   logic [BAUD_W-1:0] baud_divider_reg;
   logic exp_q[$];
   logic ack_e;
   int errors = 0, n_checks = 0, seed = 29633;
   // wired-and lines with pull-ups
   assign scl_w = ~(m_scl | scl_oe);
   assign sda_w = ~(m_sda | sda_oe);
   twa_core uut (.clock, .rst, .scl_in(scl_w), .scl_out, .scl_oe, .sda_in(sda_w), .sda_out,
      .sda_oe, .module_enable, .bus_interrupt_enable, .master_select, .transmit_select,
      .repeat_start_req, .ack_disable, .general_call_enable, .address_extension, .upper_address,
      .own_address_reg, .baud_divider_reg, .tx_data, .tx_data_wr, .clr_bus_interrupt_flag,
      .clr_arbitration_lost, .bus_data_register, .transfer_complete_flag, .addressed_as_slave_flag,
      .slave_read_write_flag, .arbitration_lost_flag, .bus_interrupt_flag, .rx_nack, .bus_busy,
      .bus_interrupt);
   twa_host_model m (.clock, .scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda), .ack_stb,
      .ack_val);
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // note the expected acknowledge (0 = ack), then send
   task automatic send(input logic [7:0] b, input logic e);
      exp_q.push_back(e);
      m.put_byte(b);
   endtask
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // compare each acknowledge against the oldest note
   always @(posedge clock) begin
      if (ack_stb) begin
         ack_e = exp_q.pop_front();
         chk("ack", {7'h00, ack_e}, {7'h00, ack_val});
         chk("rx_nack", {7'h00, ack_e}, {7'h00, rx_nack});
      end
   end
   // software stand-in: acknowledge the interrupt after a while
   initial forever begin
      @(posedge clock);
      #2;
      if (bus_interrupt_flag === 1'b1) begin
         repeat (40) @(posedge clock);
         #2;
         chk("irq", {7'h00, bus_interrupt_enable}, {7'h00, bus_interrupt});
         clr_bus_interrupt_flag = 1'b1;
         @(posedge clock);
         #2;
         clr_bus_interrupt_flag = 1'b0;
         chk("irq_drop", 8'h00, {7'h00, bus_interrupt_flag, bus_interrupt});
      end
   end
   initial begin
      #(25 * 30000);
      errors++;
      complete_run();
   end
   initial begin
      {rst, module_enable, master_select, transmit_select, repeat_start_req, ack_disable} = 6'h21;
      {general_call_enable, address_extension, tx_data_wr, upper_address} = 6'h00;
      {clr_bus_interrupt_flag, clr_arbitration_lost, bus_interrupt_enable} = 3'h0;
      baud_divider_reg = BAUD_W'($random(seed) & 3);
      tx_data = 8'($random(seed));
      own_address_reg = {2'h1, 5'($random(seed)), 1'b0};
      repeat (20) @(posedge clock);
      #2;
      rst = 1'b0;
      chk("reset", 8'h00, {scl_oe, sda_oe, scl_out, sda_out, arbitration_lost_flag,
         bus_interrupt_flag, bus_busy});
      general_call_enable = 1'b1;
      module_enable = 1'b1;
      bus_interrupt_enable = 1'($random(seed));
      repeat (4) @(posedge clock);
      #2;
      m.start();
      chk("busy", 8'h01, {7'h00, bus_busy});
      send({own_address_reg[7:1], 1'b0}, 1'b0);
      chk("addressed", 8'h03, {addressed_as_slave_flag, transfer_complete_flag});
      chk("stretch", 8'h01, {7'h00, scl_oe});
      d = 8'($random(seed));
      send(d, 1'b0);
      chk("data", d, bus_data_register);
      m.stop();
      m.start();
      send({own_address_reg[7:1] ^ 7'h01, 1'b0}, 1'b1);
      m.stop();
      m.start();
      send(GC_ADDR, 1'b0);
      chk("gc_data", GC_ADDR, bus_data_register);
      chk("gc_flag", 8'h01, {7'h00, addressed_as_slave_flag});
      m.stop();
      general_call_enable = 1'b0;
      m.start();
      send(GC_ADDR, 1'b1);
      m.stop();
      // own start on an idle bus, hold, then own stop without arbitration loss
      master_select = 1'b1;
      repeat (12) @(posedge clock);
      #2;
      chk("m_hold", 8'h05, {5'h00, scl_oe, sda_oe, bus_busy});
      master_select = 1'b0;
      repeat (30) @(posedge clock);
      #2;
      chk("m_stop", 8'h00, {4'h0, scl_oe, sda_oe, bus_busy, arbitration_lost_flag});
      address_extension = 1'b1;
      upper_address = 3'($random(seed));
      // top bit clear keeps the low byte off the reserved prefix in 7-bit mode
      own_address_reg = {1'b0, 7'($random(seed))};
      bus_interrupt_enable = 1'($random(seed));
      fb = {EXT_PREFIX, upper_address[1:0], 1'b0};
      for (int w = 0; w < 2; w++) begin
         m.start();
         send(fb, 1'b0);
         chk("first_irq", 8'h01, {7'h00, bus_interrupt_flag});
         send(own_address_reg ^ 8'(w), 1'(w));
         if (w == 0) begin
            m.start();
            send(fb | 8'h01, 1'b0);
            chk("read_dir", 8'h01, {7'h00, slave_read_write_flag});
         end
         m.stop();
      end
      for (int x = 1; x >= 0; x--) begin
         address_extension = 1'(x);
         m.start();
         send(fb | 8'h01, 1'b1);
         m.stop();
      end
      // start request while another master holds the bus
      m.start();
      master_select = 1'b1;
      @(posedge clock);
      #2;
      master_select = 1'b0;
      @(posedge clock);
      #2;
      chk("busy_arb", 8'h03, {arbitration_lost_flag, bus_interrupt_flag});
      clr_arbitration_lost = 1'b1;
      @(posedge clock);
      #2;
      clr_arbitration_lost = 1'b0;
      m.stop();
      repeat_start_req = 1'b1;
      @(posedge clock);
      #2;
      repeat_start_req = 1'b0;
      @(posedge clock);
      #2;
      chk("arb", 8'h03, {arbitration_lost_flag, bus_interrupt_flag});
      clr_arbitration_lost = 1'b1;
      @(posedge clock);
      #2;
      clr_arbitration_lost = 1'b0;
      chk("arb_clr", 8'h00, {7'h00, arbitration_lost_flag});
      repeat (60) @(posedge clock);
      complete_run();
   end
endmodule
